// >>> design/pecd_defines.vh
// constants of the extended phy control and cable diagnostic register bank
// assumes 5-bit register offsets and 16-bit register data
`ifndef PECD_DEFINES_VH
`define PECD_DEFINES_VH

// ==========================================================================
// register offsets
`define PECD_OFS_CTRL3        5'h14
`define PECD_OFS_CTRL4        5'h17
`define PECD_OFS_DIAG_AB      5'h18
`define PECD_OFS_DIAG_CD      5'h19
`define PECD_OFS_DIAG_TERM    5'h1a

// ==========================================================================
// control 3 fields
`define PECD_C3_ADDR_REV      9
`define PECD_C3_MEDIA_HI      7
`define PECD_C3_MEDIA_LO      6
`define PECD_C3_NO_PREAMBLE   5
`define PECD_C3_DS_ENABLE     4
`define PECD_C3_DS_CNT_HI     3
`define PECD_C3_DS_CNT_LO     2
`define PECD_C3_DS_STATUS     1
`define PECD_DS_CNT_DEFAULT   2'h1
`define PECD_DS_BASE_ATTEMPTS 3'h2
`define PECD_MEDIA_NONE       2'h0
`define PECD_MEDIA_COPPER     2'h1

// ==========================================================================
// control 4 fields
`define PECD_C4_ADDR_HI       15
`define PECD_C4_ADDR_LO       11
`define PECD_C4_POE_EN        10
`define PECD_C4_POE_HI        9
`define PECD_C4_POE_LO        8
`define PECD_POE_SEARCHING    2'h0
`define PECD_POE_RESERVED     2'h3
`define PECD_ADDR_KEEP_HI     4
`define PECD_ADDR_KEEP_LO     2
`define PECD_ADDR_PORT_HI     1
`define PECD_ADDR_PORT_LO     0
`define PECD_CRC_WIDTH        8

// ==========================================================================
// cable diagnostic fields
`define PECD_DG_TRIGGER       15
`define PECD_DG_VALID         14
`define PECD_DIST_WIDTH       6
`define PECD_DIST_STEP_M      3
`define PECD_DIST_HI_MSB      13
`define PECD_DIST_HI_LSB      8
`define PECD_DIST_LO_MSB      5
`define PECD_DIST_LO_LSB      0
`define PECD_TERM_OK          4'h0
`define PECD_TERM_OPEN        4'h1
`define PECD_TERM_SHORT       4'h2
`define PECD_TERM_ABNORMAL    4'h4
`define PECD_TERM_XSHORT_A    4'h8
`define PECD_TERM_XCOUPLE_A   4'hc

`endif

// >>> design/pecd_sat_counter.v
// saturating up counter with a synchronous clear
// assumes inc and clear are synchronous to clk; an increment beside a clear yields one
`timescale 1ns/1ps

module pecd_sat_counter #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // control
  input  wire             clear,
  input  wire             inc,
  // state
  output reg  [WIDTH-1:0] count
);

  // ========================================================================
  // counter
  wire atMax;
  assign atMax = &count;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= {WIDTH{1'b0}};
    end else if (clear) begin
      // the event beside a clear is kept, it starts the new count
      count <= inc ? {{(WIDTH-1){1'b0}}, 1'b1} : {WIDTH{1'b0}};
    end else if (inc && !atMax) begin
      count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // pecd_sat_counter

// >>> design/pecd_regs.v
// extended phy control, inline power, crc error and cable diagnostic register bank of one port
// assumes a register port with read data one cycle after the read strobe, and
// analog/pcs side events that are single-cycle pulses synchronous to ref_clk
`timescale 1ns/1ps
`include "pecd_defines.vh"

module pecd_regs #(
  parameter ADDR_WIDTH = 5,
  parameter DATA_WIDTH = 16,
  parameter FAIL_WIDTH = 3
) (
  // clock and reset
  input  wire                  ref_clk,
  input  wire                  rst,
  input  wire                  softReset,
  // register port
  input  wire [ADDR_WIDTH-1:0] regAddr,
  input  wire [DATA_WIDTH-1:0] regWrData,
  input  wire                  regWr,
  input  wire                  regRd,
  output reg  [DATA_WIDTH-1:0] regRdData,
  // addressing
  input  wire [4:0]            phyAddrStrap,
  input  wire [1:0]            physPort,
  output reg  [4:0]            mgmtAddr,
  // media and receive
  input  wire                  copperSelected,
  input  wire                  crcErrFrame,
  output reg                   noPreambleEn,
  // gigabit downshift
  input  wire                  gigAnegFail,
  input  wire                  gigLinkUp,
  output reg                   downshiftActive,
  // inline power detection
  input  wire [1:0]            poeDetResult,
  output reg                   poeDetEnable,
  // cable diagnostic engine
  output reg                   diagStart,
  input  wire                  diagDone,
  input  wire [5:0]            diagDistA,
  input  wire [5:0]            diagDistB,
  input  wire [5:0]            diagDistC,
  input  wire [5:0]            diagDistD,
  input  wire [3:0]            diagTermA,
  input  wire [3:0]            diagTermB,
  input  wire [3:0]            diagTermC,
  input  wire [3:0]            diagTermD
);

  // ========================================================================
  // diagnostic states
  localparam DG_IDLE = 1'b0;
  localparam DG_RUN  = 1'b1;

  // ========================================================================
  // decode
  wire wrCtrl3;
  wire wrDiag;
  wire rdCtrl4;
  wire wrCtrl4;
  assign wrCtrl3 = regWr && (regAddr == `PECD_OFS_CTRL3);
  assign wrCtrl4 = regWr && (regAddr == `PECD_OFS_CTRL4);
  assign wrDiag  = regWr && (regAddr == `PECD_OFS_DIAG_AB);
  assign rdCtrl4 = regRd && (regAddr == `PECD_OFS_CTRL4);

  // ========================================================================
  // address latch
  reg       addrCaptured;
  reg [4:0] latchedAddr;

  // the strap is sampled by the first clock after reset release, never by the reset itself
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addrCaptured <= 1'b0;
      latchedAddr  <= 5'h00;
    end else if (!addrCaptured) begin
      addrCaptured <= 1'b1;
      latchedAddr  <= phyAddrStrap;
    end
  end

  // ========================================================================
  // control 3 fields
  reg       addrReverse;
  reg       downshiftEn;
  reg [1:0] downshiftCnt;

  // address reversal is not sticky, so a port reset returns it to natural order
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addrReverse <= 1'b0;
    end else if (softReset) begin
      addrReverse <= 1'b0;
    end else if (wrCtrl3) begin
      addrReverse <= regWrData[`PECD_C3_ADDR_REV];
    end
  end

  // sticky fields ignore the port reset
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      noPreambleEn <= 1'b0;
      downshiftEn  <= 1'b0;
      downshiftCnt <= `PECD_DS_CNT_DEFAULT;
    end else if (wrCtrl3) begin
      noPreambleEn <= regWrData[`PECD_C3_NO_PREAMBLE];
      downshiftEn  <= regWrData[`PECD_C3_DS_ENABLE];
      downshiftCnt <= regWrData[`PECD_C3_DS_CNT_HI:`PECD_C3_DS_CNT_LO];
    end
  end

  // software is expected to flip reversal from the port that keeps its address
  // the block itself obeys whatever each port was told
  reg [4:0] next_mgmtAddr;

  always @* begin
    next_mgmtAddr = {latchedAddr[`PECD_ADDR_KEEP_HI:`PECD_ADDR_KEEP_LO], physPort};
    if (addrReverse) begin
      next_mgmtAddr[`PECD_ADDR_PORT_HI:`PECD_ADDR_PORT_LO] = ~physPort;
    end
  end

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mgmtAddr <= 5'h00;
    end else begin
      mgmtAddr <= next_mgmtAddr;
    end
  end

  // ========================================================================
  // downshift
  wire [FAIL_WIDTH-1:0] failCount;
  wire [FAIL_WIDTH-1:0] failLimit;
  wire                  failClear;
  wire                  failInc;
  wire                  failReached;

  assign failLimit = {{(FAIL_WIDTH-2){1'b0}}, downshiftCnt} + `PECD_DS_BASE_ATTEMPTS;
  assign failClear = softReset || gigLinkUp || !downshiftEn;
  assign failInc   = gigAnegFail && downshiftEn;
  // the fail counter saturates, so extra attempts can never wrap below the limit
  assign failReached = (failCount >= failLimit);

  pecd_sat_counter #(
    .WIDTH (FAIL_WIDTH)
  ) uFailCounter (
    .clk   (ref_clk),
    .rst   (rst),
    .clear (failClear),
    .inc   (failInc),
    .count (failCount)
  );

  // once required the status holds until the port is reset or the feature is turned off
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      downshiftActive <= 1'b0;
    end else if (softReset || !downshiftEn) begin
      downshiftActive <= 1'b0;
    end else if (failReached) begin
      downshiftActive <= 1'b1;
    end
  end

  // ========================================================================
  // inline power detection and crc errors
  wire [`PECD_CRC_WIDTH-1:0] crcErrCount;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      poeDetEnable <= 1'b0;
    end else if (wrCtrl4) begin
      poeDetEnable <= regWrData[`PECD_C4_POE_EN];
    end
  end

  // a frame arriving in the cycle of the clearing read counts toward the next read
  pecd_sat_counter #(
    .WIDTH (`PECD_CRC_WIDTH)
  ) uCrcCounter (
    .clk   (ref_clk),
    .rst   (rst),
    .clear (rdCtrl4 || softReset),
    .inc   (crcErrFrame),
    .count (crcErrCount)
  );

  // ========================================================================
  // cable diagnostic engine control
  reg       dgState;
  reg       diagValid;
  reg [5:0] distA;
  reg [5:0] distB;
  reg [5:0] distC;
  reg [5:0] distD;
  reg [3:0] termA;
  reg [3:0] termB;
  reg [3:0] termC;
  reg [3:0] termD;
  wire      diagBusy;

  assign diagBusy = (dgState == DG_RUN);

  // codes 3, 5, 6 and 7 are reported as abnormal termination; codes with bit 3 set pass unchanged
  function [3:0] cleanTerm;
    input [3:0] code;
    begin
      if (code[3]) begin
        cleanTerm = code;
      end else if ((code == `PECD_TERM_OK) || (code == `PECD_TERM_OPEN) ||
                   (code == `PECD_TERM_SHORT)) begin
        cleanTerm = code;
      end else begin
        cleanTerm = `PECD_TERM_ABNORMAL;
      end
    end
  endfunction

  // distances are raw steps of PECD_DIST_STEP_M meters, no scaling here
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dgState   <= DG_IDLE;
      diagStart <= 1'b0;
      diagValid <= 1'b0;
      distA     <= 6'h00;
      distB     <= 6'h00;
      distC     <= 6'h00;
      distD     <= 6'h00;
      termA     <= 4'h0;
      termB     <= 4'h0;
      termC     <= 4'h0;
      termD     <= 4'h0;
    end else begin
      diagStart <= 1'b0;
      case (dgState)
        DG_IDLE: begin
          if (wrDiag && regWrData[`PECD_DG_TRIGGER]) begin
            dgState   <= DG_RUN;
            diagStart <= 1'b1;
            diagValid <= 1'b0;
          end
        end
        DG_RUN: begin
          if (softReset) begin
            dgState <= DG_IDLE;
          end else if (diagDone) begin
            dgState   <= DG_IDLE;
            diagValid <= 1'b1;
            distA     <= diagDistA;
            distB     <= diagDistB;
            distC     <= diagDistC;
            distD     <= diagDistD;
            termA     <= cleanTerm(diagTermA);
            termB     <= cleanTerm(diagTermB);
            termC     <= cleanTerm(diagTermC);
            termD     <= cleanTerm(diagTermD);
          end
        end
        default: begin
          dgState <= DG_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // read mux
  reg [DATA_WIDTH-1:0] next_regRdData;
  wire [1:0]           mediaStatus;
  wire [1:0]           poeStatus;

  assign mediaStatus = copperSelected ? `PECD_MEDIA_COPPER : `PECD_MEDIA_NONE;
  // a reserved detector code reads as searching, so software never sees 11
  assign poeStatus   = (!poeDetEnable || (poeDetResult == `PECD_POE_RESERVED)) ?
                       `PECD_POE_SEARCHING : poeDetResult;

  always @* begin
    next_regRdData = {DATA_WIDTH{1'b0}};
    case (regAddr)
      `PECD_OFS_CTRL3: begin
        next_regRdData[`PECD_C3_ADDR_REV]    = addrReverse;
        next_regRdData[`PECD_C3_MEDIA_HI:`PECD_C3_MEDIA_LO] = mediaStatus;
        next_regRdData[`PECD_C3_NO_PREAMBLE] = noPreambleEn;
        next_regRdData[`PECD_C3_DS_ENABLE]   = downshiftEn;
        next_regRdData[`PECD_C3_DS_CNT_HI:`PECD_C3_DS_CNT_LO] = downshiftCnt;
        next_regRdData[`PECD_C3_DS_STATUS]   = downshiftActive;
      end
      `PECD_OFS_CTRL4: begin
        next_regRdData[`PECD_C4_ADDR_HI:`PECD_C4_ADDR_LO] = latchedAddr;
        next_regRdData[`PECD_C4_POE_EN] = poeDetEnable;
        next_regRdData[`PECD_C4_POE_HI:`PECD_C4_POE_LO] = poeStatus;
        next_regRdData[`PECD_CRC_WIDTH-1:0] = crcErrCount;
      end
      `PECD_OFS_DIAG_AB: begin
        next_regRdData[`PECD_DG_TRIGGER] = diagBusy;
        next_regRdData[`PECD_DG_VALID]   = diagValid;
        next_regRdData[`PECD_DIST_HI_MSB:`PECD_DIST_HI_LSB] = distA;
        next_regRdData[`PECD_DIST_LO_MSB:`PECD_DIST_LO_LSB] = distB;
      end
      `PECD_OFS_DIAG_CD: begin
        next_regRdData[`PECD_DIST_HI_MSB:`PECD_DIST_HI_LSB] = distC;
        next_regRdData[`PECD_DIST_LO_MSB:`PECD_DIST_LO_LSB] = distD;
      end
      `PECD_OFS_DIAG_TERM: begin
        next_regRdData = {termA, termB, termC, termD};
      end
      default: begin
        next_regRdData = {DATA_WIDTH{1'b0}};
      end
    endcase
  end

  // read data stands only in the cycle after the strobe
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= {DATA_WIDTH{1'b0}};
    end else begin
      regRdData <= regRd ? next_regRdData : {DATA_WIDTH{1'b0}};
    end
  end

endmodule // pecd_regs

// >>> verification/pecd_regs_props.sv
// concurrent checks on the ports of the extended phy control register bank
// assumes the bank sits at the testbench top as u_dut, one clock, async high reset
`timescale 1ns/1ps

module pecd_regs_props #(
  parameter ADDR_WIDTH = 5,
  parameter DATA_WIDTH = 16
) (
  // clock and reset
  input wire                  ref_clk,
  input wire                  rst,
  input wire                  softReset,
  // register port
  input wire [ADDR_WIDTH-1:0] regAddr,
  input wire [DATA_WIDTH-1:0] regWrData,
  input wire                  regWr,
  input wire                  regRd,
  input wire [DATA_WIDTH-1:0] regRdData,
  // side signals
  input wire [1:0]            physPort,
  input wire [4:0]            mgmtAddr,
  input wire                  crcErrFrame,
  input wire                  noPreambleEn,
  input wire                  downshiftActive,
  input wire                  poeDetEnable,
  input wire                  diagStart
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // ==========================================================================
  // helpers: cycles since reset, shadow of the reversal bit
  // mgmtAddr only settles on the second edge after reset, so checks wait for it
  logic [1:0] upCnt;
  logic       revShadow;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upCnt     <= 2'h0;
      revShadow <= 1'b0;
    end else begin
      upCnt <= (upCnt == 2'h3) ? upCnt : upCnt + 2'h1;
      if (softReset)
        revShadow <= 1'b0;
      else if (regWr && regAddr == 5'h14)
        revShadow <= regWrData[9];
    end
  end

  // ==========================================================================
  // properties
  property p_rdIdle;     !regRd |=> regRdData == '0; endproperty
  property p_mgmt;
    upCnt == 2'h3 |-> mgmtAddr[1:0] == ($past(revShadow) ? ~$past(physPort) : $past(physPort));
  endproperty
  property p_noPre;      regWr && regAddr == 5'h14 |=> noPreambleEn == $past(regWrData[5]); endproperty
  property p_poeEn;      regWr && regAddr == 5'h17 |=> poeDetEnable == $past(regWrData[10]); endproperty
  property p_diagCause;
    diagStart |-> $past(regWr) && $past(regAddr) == 5'h18 && $past(regWrData[15]);
  endproperty
  property p_diagPulse;  diagStart |=> !diagStart; endproperty
  property p_softDs;     softReset |=> !downshiftActive; endproperty
  sequence s_crcRd;      regRd && regAddr == 5'h17 && !crcErrFrame; endsequence
  property p_crcRead;    s_crcRd ##1 s_crcRd |=> regRdData[7:0] == 8'h00; endproperty
  property p_unmapped;   regRd && regAddr == 5'h1f |=> regRdData == '0; endproperty
  property p_strap;
    regRd && regAddr == 5'h17 && upCnt == 2'h3 |=> regRdData[15:13] == mgmtAddr[4:2];
  endproperty

  a_rdIdle:    assert property (p_rdIdle)    else $error("read data not zero outside read slot");
  a_mgmt:      assert property (p_mgmt)      else $error("management address low bits wrong");
  a_noPre:     assert property (p_noPre)     else $error("no preamble enable not following write");
  a_poeEn:     assert property (p_poeEn)     else $error("power detect enable not following write");
  a_diagCause: assert property (p_diagCause) else $error("diagnostic start without trigger write");
  a_diagPulse: assert property (p_diagPulse) else $error("diagnostic start longer than one cycle");
  a_softDs:    assert property (p_softDs)    else $error("downshift kept over port reset");
  a_crcRead:   assert property (p_crcRead)   else $error("crc counter not cleared by read");
  a_unmapped:  assert property (p_unmapped)  else $error("unmapped read returned data");
  a_strap:     assert property (p_strap)     else $error("latched address field disagrees");

  c_diag:  cover property (diagStart);
  c_ds:    cover property ($rose(downshiftActive));
  c_crc:   cover property (s_crcRd ##1 s_crcRd);
endmodule // pecd_regs_props

bind pecd_regs pecd_regs_props #(.ADDR_WIDTH(ADDR_WIDTH), .DATA_WIDTH(DATA_WIDTH)) u_props (
  .ref_clk, .rst, .softReset, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .physPort,
  .mgmtAddr, .crcErrFrame, .noPreambleEn, .downshiftActive, .poeDetEnable, .diagStart);

// >>> verification/testbench.sv
// self-checking bench of the extended phy control register bank
// assumes the bank alone, driven at its ports; reads are checked through a queue
`timescale 1ns/1ps
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin badCount++; \
  $display("BAD t=%0t got=%h exp=%h", $time, got, exp); end end

module testbench;
  logic        ref_clk = 0, rst = 1, softReset = 0;
  logic [4:0]  regAddr = 0;
  logic [15:0] regWrData = 0, regRdData, e;
  logic        regWr = 0, regRd = 0, rdSeen = 0;
  logic [1:0]  physPort = 0, poeDetResult = 0;
  logic [4:0]  mgmtAddr;
  logic        copperSelected = 0, crcErrFrame = 0, gigAnegFail = 0, gigLinkUp = 0, diagDone = 0;
  logic        noPreambleEn, downshiftActive, poeDetEnable, diagStart;
  logic [5:0]  dA = 0, dB = 0, dC = 0, dD = 0;
  logic [3:0]  tA = 0, tB = 0, tC = 0, tD = 0;
  logic [15:0] expQ[$];
  logic [31:0] seed = 32'h8949;
  int          badCount = 0, testsRun = 0, n;
  // strap value is arbitrary
  localparam logic [4:0] STRAP = 5'h15;
  localparam logic [3:0] CODES [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
                                       4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};

  always #20 ref_clk = ~ref_clk;

  pecd_regs u_dut (.ref_clk(ref_clk), .rst(rst), .softReset(softReset), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .phyAddrStrap(STRAP), .physPort(physPort), .mgmtAddr(mgmtAddr), .copperSelected(copperSelected),
    .crcErrFrame(crcErrFrame), .noPreambleEn(noPreambleEn), .gigAnegFail(gigAnegFail),
    .gigLinkUp(gigLinkUp), .downshiftActive(downshiftActive), .poeDetResult(poeDetResult),
    .poeDetEnable(poeDetEnable), .diagStart(diagStart), .diagDone(diagDone),
    .diagDistA(dA), .diagDistB(dB), .diagDistC(dC), .diagDistD(dD),
    .diagTermA(tA), .diagTermB(tB), .diagTermC(tC), .diagTermD(tD));

  // ==========================================================================
  // read data monitor: one note per read strobe, checked where the data stand
  always @(posedge ref_clk) rdSeen <= regRd;
  always @(negedge ref_clk) begin
    if (rdSeen) begin
      e = expQ.pop_front();
      `CHK(regRdData, e)
    end
  end

  // ==========================================================================
  // bus tasks: entered right after a rising edge, leave right after the taking edge
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // codes 3, 5, 6 and 7 are folded into abnormal termination, codes 8 to f pass unchanged
  function automatic logic [3:0] fold(input logic [3:0] c);
    return (c == 4'h3 || c == 4'h5 || c == 4'h6 || c == 4'h7) ? 4'h4 : c;
  endfunction
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a; regWrData <= d; regWr <= 1; regRd <= 0;
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] x);
    expQ.push_back(x);
    regAddr <= a; regRd <= 1; regWr <= 0;
    @(posedge ref_clk);
  endtask
  task automatic idle(input int c);
    regWr <= 0; regRd <= 0;
    repeat (c) @(posedge ref_clk);
  endtask
  task automatic pulse(input int c, input bit crc);
    regWr <= 0; regRd <= 0;
    repeat (c) begin
      if (crc) crcErrFrame <= 1; else gigAnegFail <= 1;
      @(posedge ref_clk);
      crcErrFrame <= 0; gigAnegFail <= 0;
      @(posedge ref_clk);
    end
  endtask
  task automatic portReset;
    regWr <= 0; regRd <= 0;
    softReset <= 1; @(posedge ref_clk); softReset <= 0; @(posedge ref_clk);
  endtask
  task automatic chkAddr(input bit rev);
    for (int p = 0; p < 4; p++) begin
      physPort <= p[1:0]; idle(3); @(negedge ref_clk);
      `CHK(mgmtAddr, {STRAP[4:2], rev ? ~p[1:0] : p[1:0]})
      @(posedge ref_clk);
    end
  endtask
  task automatic trig(input bit start);
    wr(5'h18, 16'h8000); idle(0); @(negedge ref_clk);
    `CHK(diagStart, start)
    @(posedge ref_clk);
  endtask
  task automatic completeRun;
    if (expQ.size() != 0) badCount++;
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #(40 * 30000); badCount++; completeRun();
  end

  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst <= 0;
    @(posedge ref_clk);
    rd(5'h14, 16'h0004);
    rd(5'h17, {STRAP, 11'h0});
    rd(5'h18, 16'h0); rd(5'h19, 16'h0); rd(5'h1a, 16'h0);
    rd(5'h1f, 16'h0); wr(5'h1f, 16'hffff); rd(5'h1f, 16'h0);
    chkAddr(0);
    copperSelected <= 1;
    physPort <= 2'h0;
    // read-only bits in the written word must be ignored
    wr(5'h14, 16'h02fe); idle(1);
    rd(5'h14, 16'h027c); idle(1);
    `CHK(noPreambleEn, 1'b1)
    chkAddr(1);
    portReset();
    rd(5'h14, 16'h007c); idle(1);
    `CHK(noPreambleEn, 1'b1)
    // downshift disabled: failures never trigger it
    wr(5'h14, 16'h0000); pulse(4, 0); idle(3);
    `CHK(downshiftActive, 1'b0)
    for (int c = 0; c < 4; c++) begin
      portReset();
      wr(5'h14, 16'h0010 | (c << 2)); pulse(c + 1, 0); idle(3);
      `CHK(downshiftActive, 1'b0)
      pulse(1, 0); idle(3);
      `CHK(downshiftActive, 1'b1)
      rd(5'h14, 16'h0052 | (c << 2));
    end
    wr(5'h17, 16'h0400);
    for (int r = 0; r < 4; r++) begin
      poeDetResult <= r[1:0]; idle(2);
      rd(5'h17, {STRAP, 1'b1, (r == 3) ? 2'h0 : r[1:0], 8'h0});
    end
    wr(5'h17, 16'h0000); idle(2);
    rd(5'h17, {STRAP, 11'h0});
    seed = lfsr(seed); n = seed[5:0] + 1;
    idle(0); pulse(n, 1);
    rd(5'h17, {STRAP, 3'h0, n[7:0]}); rd(5'h17, {STRAP, 11'h0});
    idle(0); pulse(300, 1);
    rd(5'h17, {STRAP, 11'h0ff}); rd(5'h17, {STRAP, 11'h0});
    for (int k = 0; k < 4; k++) begin
      trig(1);
      rd(5'h18, {2'h2, dA, 2'h0, dB});
      trig(0);
      seed = lfsr(seed);
      dA <= seed[5:0]; dB <= seed[11:6]; dC <= seed[17:12]; dD <= seed[23:18];
      tA <= CODES[4*k]; tB <= CODES[4*k+1]; tC <= CODES[4*k+2]; tD <= CODES[4*k+3];
      diagDone <= 1; idle(1); diagDone <= 0;
      rd(5'h18, {2'h1, dA, 2'h0, dB});
      rd(5'h19, {2'h0, dC, 2'h0, dD});
      rd(5'h1a, {fold(tA), fold(tB), fold(tC), fold(tD)});
    end
    wr(5'h19, 16'hffff); rd(5'h19, {2'h0, dC, 2'h0, dD});
    idle(3);
    completeRun();
  end
endmodule // testbench
